//--- hdl/rtccsp_top.sv
// serial command port of the clock/calendar device: command decode, memories, write cycle, alarm pin
// assumes chip select, serial clock and serial input arrive asynchronously and are sampled here
//
// What this block does
// - select only while chip select low
// - running write cycle finishes despite chip select
// - serial output released whenever deselected
// - chip select rise launches write, within 5 ms
// - sample input on rise, drive output on fall
// - read bits appear after falling clock edge
// - first bit taken at first rise after select
// - everything msb first, opcodes eight bits
// - array read/write and status read/write opcodes
// - opcodes set and clear write enable latch
// - opcodes read and write clock/sram space
// - unlock, write and read the id area
// - opcode clears sram bytes to zero
// - array, clock and id reads are opcode, address, then data
// - pointer advances after each byte read
// - pointer wraps to first valid address
// - clock space 00-1f, sram 20-5f only
// - time/date and configuration addresses
// - alarm and time stamp addresses
// - second alarm has finer resolution
// - time values accepted without checking
// - open drain alarm pin holds until cleared
// - nonvolatile write needs latch, clears after
// - page write holds eight bytes, wraps
`timescale 1ns/1ps
module rtccsp_top #(
   parameter int unsigned WRITE_CYCLES = rtccsp_pkg::WRITE_CYCLES_DEF
) (
   input  wire logic mclk_in,
   input  wire logic rst_b_in,
   input  wire logic cs_b_in,
   input  wire logic sck_in,
   input  wire logic si_in,
   input  wire logic alarm0_event_in,
   input  wire logic alarm1_event_in,
   output logic      so_out,
   output logic      so_oe_b_out,
   output logic      mfp_out,
   output logic      mfp_oe_b_out
);
   import rtccsp_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_RD, ST_WR, ST_HOLD, ST_IGN} rtccsp_state_t;

   logic          cs_s1, cs_s2, cs_s3;    // chip select synchroniser and history
   logic          sck_s1, sck_s2, sck_s3; // serial clock synchroniser and history
   logic          si_s1, si_s2;           // serial input synchroniser
   logic          cs_fall, cs_rise;       // chip select edges
   logic          sck_rise, sck_fall;     // serial clock edges while selected
   rtccsp_state_t state;                  // command phase
   logic [2:0]    bit_cnt;                // bits taken in current byte
   logic [7:0]    shreg;                  // incoming bits
   logic [7:0]    in_byte;                // byte completed by this rising edge
   logic          byte_done;              // eighth bit taken now
   logic [7:0]    opcode;                 // current command
   logic [7:0]    ptr;                    // address pointer
   logic [7:0]    sout;                   // outgoing byte
   logic          load_pend;              // next falling edge loads a new byte
   logic [7:0]    rd_byte;                // byte selected for reading
   logic          wel;                    // write enable latch
   logic          wip;                    // write cycle running
   logic          id_unlock;              // id area unlocked
   logic [1:0]    bp;                     // block protect bits
   logic [7:0]    pbuf [PAGE_BYTES];      // page buffer
   logic [7:0]    pmask;                  // page bytes present
   logic [7:0]    pbase;                  // page start address
   rtccsp_tgt_t   tgt;                    // page destination
   logic [15:0]   timer;                  // write cycle time
   logic          clr_run;                // sram clear running
   logic [6:0]    clr_cnt;                // sram clear index
   logic          alm0_flag, alm1_flag;   // sticky alarm flags
   logic          push_vol;               // volatile byte to fifo
   logic [7:0]    vol_rdata, nv_rdata, id_rdata;
   logic          nv_we, id_we, vol_we;
   logic [6:0]    vol_waddr;
   logic [7:0]    vol_wdata;
   logic          launch;                 // write cycle starts

   rtccsp_stream_if #(.W(FIFO_WIDTH)) push_if ();
   rtccsp_stream_if #(.W(FIFO_WIDTH)) drain_if ();

   // next read address with wrap per space
   function automatic logic [7:0] next_ptr(input logic [7:0] op, input logic [7:0] p);
      logic [7:0] n;
      n = 8'(p + 8'h01);
      if (op == CLOCK_READ_CMD || op == CLOCK_WRITE_CMD) begin
         if (p == CLOCK_LAST) n = CLOCK_FIRST;
         else if (p == SRAM_LAST) n = SRAM_FIRST;
      end else if (op == ID_AREA_READ_CMD) begin
         n = {4'h0, 4'(p[3:0] + 4'h1)};
      end
      return n;
   endfunction

   // opcodes that this port serves
   function automatic logic is_known(input logic [7:0] op);
      return op inside {NV_ARRAY_READ_CMD, NV_ARRAY_WRITE_CMD, WRITE_LATCH_CLEAR_CMD, WRITE_LATCH_SET_CMD,
                        STATUS_READ_CMD, STATUS_WRITE_CMD, CLOCK_READ_CMD, CLOCK_WRITE_CMD, ID_UNLOCK_CMD,
                        ID_AREA_WRITE_CMD, ID_AREA_READ_CMD, SRAM_CLEAR_CMD};
   endfunction

   // two-stage synchronisers, plus one history stage on chip select and serial clock for edge finding
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         {cs_s1, cs_s2, cs_s3}    <= 3'h7;
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {si_s1, si_s2}           <= 2'h0;
      end else begin
         {cs_s1, cs_s2, cs_s3}    <= {cs_b_in, cs_s1, cs_s2};
         {sck_s1, sck_s2, sck_s3} <= {sck_in, sck_s1, sck_s2};
         {si_s1, si_s2}           <= {si_in, si_s1};
      end
   end

   assign cs_fall   = !cs_s2 && cs_s3;
   assign cs_rise   = cs_s2 && !cs_s3;
   assign sck_rise  = sck_s2 && !sck_s3 && !cs_s2 && !cs_s3;
   assign sck_fall  = !sck_s2 && sck_s3 && !cs_s2 && !cs_s3;
   assign in_byte   = {shreg[6:0], si_s2};
   assign byte_done = sck_rise && (bit_cnt == 3'h7);

   // command phase sequencing
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         state <= ST_IDLE;
      end else if (cs_rise || cs_s2) begin
         state <= ST_IDLE;
      end else if (cs_fall) begin
         state <= ST_OPC;
      end else if (sck_rise) begin
         case (state)
            ST_OPC: begin
               if (byte_done) begin
                  if (!is_known(in_byte)) state <= ST_IGN;
                  else if (wip && in_byte != STATUS_READ_CMD) state <= ST_IGN;
                  else if (in_byte == STATUS_READ_CMD) state <= ST_RD;
                  else if (in_byte == STATUS_WRITE_CMD) state <= ST_WR;
                  else if (in_byte inside {WRITE_LATCH_SET_CMD, WRITE_LATCH_CLEAR_CMD, ID_UNLOCK_CMD,
                                           SRAM_CLEAR_CMD}) state <= ST_HOLD;
                  else state <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (byte_done) begin
                  state <= (opcode inside {NV_ARRAY_READ_CMD, CLOCK_READ_CMD, ID_AREA_READ_CMD}) ? ST_RD : ST_WR;
               end
            end
            ST_HOLD: state <= ST_IGN; // extra bits spoil a one-byte command
            ST_RD, ST_WR, ST_IGN: state <= state;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // bit counting and input shifting
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         bit_cnt <= 3'h0;
         shreg   <= 8'h00;
         opcode  <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt <= 3'h0;
      end else if (sck_rise) begin
         bit_cnt <= 3'(bit_cnt + 3'h1);
         shreg   <= in_byte;
         if (byte_done && state == ST_OPC) opcode <= in_byte;
      end
   end

   // address pointer: loaded from the address byte, advanced per byte
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         ptr       <= 8'h00;
         load_pend <= 1'b0;
      end else if (byte_done) begin
         if (state == ST_OPC) begin
            load_pend <= 1'b1;
         end else if (state == ST_ADDR) begin
            ptr       <= in_byte;
            load_pend <= 1'b1;
         end else if (state == ST_RD) begin
            ptr       <= next_ptr(opcode, ptr);
            load_pend <= 1'b1;
         end else if (state == ST_WR && opcode == CLOCK_WRITE_CMD) begin
            ptr <= next_ptr(opcode, ptr);
         end else if (state == ST_WR && opcode != STATUS_WRITE_CMD) begin
            ptr <= {ptr[7:3], 3'(ptr[2:0] + 3'h1)};
         end
      end else if (sck_fall && state == ST_RD) begin
         load_pend <= 1'b0;
      end
   end

   // read data selection; out of range clock/sram reads return zero
   always_comb begin
      rd_byte = 8'h00;
      case (opcode)
         STATUS_READ_CMD:  rd_byte = {4'h0, bp, wel, wip};
         NV_ARRAY_READ_CMD: rd_byte = nv_rdata;
         ID_AREA_READ_CMD: rd_byte = id_rdata;
         CLOCK_READ_CMD: begin
            if (ptr <= SRAM_LAST) rd_byte = vol_rdata;
            if (ptr == ALARM0_FLAG_ADDR) rd_byte[ALARM_FLAG_BIT] = alm0_flag;
            if (ptr == ALARM1_FLAG_ADDR) rd_byte[ALARM_FLAG_BIT] = alm1_flag;
         end
         default: rd_byte = 8'h00;
      endcase
   end

   // serial output: loaded or shifted after falling edges, enabled only for read data
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         sout        <= 8'h00;
         so_out      <= 1'b0;
         so_oe_b_out <= 1'b1;
      end else if (state != ST_RD) begin
         so_oe_b_out <= 1'b1;
      end else if (sck_fall) begin
         so_oe_b_out <= 1'b0;
         if (load_pend) begin
            sout   <= {rd_byte[6:0], 1'b0};
            so_out <= rd_byte[7];
         end else begin
            sout   <= {sout[6:0], 1'b0};
            so_out <= sout[7];
         end
      end
   end

   // serial volatile writes go through the fifo, sram clear writes bypass it; values are stored unchecked
   assign push_vol       = byte_done && state == ST_WR && opcode == CLOCK_WRITE_CMD && ptr <= SRAM_LAST;
   assign push_if.valid  = push_vol;
   assign push_if.data   = {ptr[6:0], in_byte};
   assign drain_if.ready = !clr_run;
   assign vol_we         = clr_run || (drain_if.valid && drain_if.ready);
   assign vol_waddr      = clr_run ? 7'(SRAM_FIRST[6:0] + clr_cnt) : drain_if.data[14:8];
   assign vol_wdata      = clr_run ? 8'h00 : drain_if.data[7:0];

   // page buffer for nonvolatile writes
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         pmask <= 8'h00;
         pbase <= 8'h00;
         tgt   <= TGT_NV;
      end else if (cs_fall && !wip) begin
         pmask <= 8'h00;
      end else if (byte_done && state == ST_WR && !wip) begin
         if (opcode == STATUS_WRITE_CMD) begin
            pbuf[0]  <= in_byte;
            pmask[0] <= 1'b1;
            tgt      <= TGT_STATUS;
         end else if (opcode inside {NV_ARRAY_WRITE_CMD, ID_AREA_WRITE_CMD}) begin
            pbuf[ptr[2:0]]  <= in_byte;
            pmask[ptr[2:0]] <= 1'b1;
            pbase           <= ptr;
            tgt             <= (opcode == ID_AREA_WRITE_CMD) ? TGT_ID : TGT_NV;
         end
      end
   end

   // a write launches only at a byte boundary with the latch set
   assign launch = cs_rise && !wip && state == ST_WR && bit_cnt == 3'h0 && pmask != 8'h00 && wel
                   && (opcode != ID_AREA_WRITE_CMD || id_unlock);

   // write cycle timer, latch and protect bits
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         wip       <= 1'b0;
         wel       <= 1'b0;
         id_unlock <= 1'b0;
         bp        <= BP_RESET;
         timer     <= 16'h0000;
      end else if (wip) begin
         timer <= 16'(timer + 16'h0001);
         if (timer == 16'h0000 && tgt == TGT_STATUS) bp <= pbuf[0][STATUS_BP_LSB +: 2];
         if (timer == 16'(WRITE_CYCLES - 1)) begin
            wip       <= 1'b0;
            wel       <= 1'b0;
            id_unlock <= 1'b0;
         end
      end else if (launch) begin
         wip   <= 1'b1;
         timer <= 16'h0000;
      end else if (cs_rise && state == ST_HOLD && bit_cnt == 3'h0) begin
         if (opcode == WRITE_LATCH_SET_CMD) wel <= 1'b1;
         if (opcode == WRITE_LATCH_CLEAR_CMD) wel <= 1'b0;
         if (opcode == ID_UNLOCK_CMD) id_unlock <= 1'b1;
      end
   end

   // committed page bytes are written in the first cycles of the write time
   assign nv_we = wip && timer < 16'(PAGE_BYTES) && tgt == TGT_NV && pmask[timer[2:0]];
   assign id_we = wip && timer < 16'(PAGE_BYTES) && tgt == TGT_ID && pmask[timer[2:0]];

   // sram clear sequencer
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         clr_run <= 1'b0;
         clr_cnt <= 7'h00;
      end else if (clr_run) begin
         clr_cnt <= 7'(clr_cnt + 7'h01);
         if (clr_cnt == SRAM_CLEAR_LAST) clr_run <= 1'b0;
      end else if (cs_rise && state == ST_HOLD && bit_cnt == 3'h0 && opcode == SRAM_CLEAR_CMD) begin
         clr_run <= 1'b1;
         clr_cnt <= 7'h00;
      end
   end

   // sticky alarm flags: a new event wins over a clearing write
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         alm0_flag <= 1'b0;
         alm1_flag <= 1'b0;
      end else begin
         if (alarm0_event_in) alm0_flag <= 1'b1;
         else if (push_vol && ptr == ALARM0_FLAG_ADDR && !in_byte[ALARM_FLAG_BIT]) alm0_flag <= 1'b0;
         if (alarm1_event_in) alm1_flag <= 1'b1;
         else if (push_vol && ptr == ALARM1_FLAG_ADDR && !in_byte[ALARM_FLAG_BIT]) alm1_flag <= 1'b0;
      end
   end

   // open drain pin: pulls low while any flag stands
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         mfp_out      <= 1'b0;
         mfp_oe_b_out <= 1'b1;
      end else begin
         mfp_out      <= 1'b0;
         mfp_oe_b_out <= !(alm0_flag || alm1_flag);
      end
   end

   rtccsp_fifo #(.W(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_in (mclk_in),
      .rst_b_in(rst_b_in),
      .wr_if   (push_if),
      .rd_if   (drain_if)
   );
   rtccsp_ram #(.DEPTH(VOL_DEPTH), .AW(7)) u_vol (
      .mclk_in  (mclk_in),
      .we_in    (vol_we),
      .waddr_in (vol_waddr),
      .wdata_in (vol_wdata),
      .raddr_in (ptr[6:0]),
      .rdata_out(vol_rdata)
   );
   rtccsp_ram #(.DEPTH(NV_DEPTH), .AW(8)) u_nv (
      .mclk_in  (mclk_in),
      .we_in    (nv_we),
      .waddr_in ({pbase[7:3], timer[2:0]}),
      .wdata_in (pbuf[timer[2:0]]),
      .raddr_in (ptr),
      .rdata_out(nv_rdata)
   );
   rtccsp_ram #(.DEPTH(ID_DEPTH), .AW(4)) u_id (
      .mclk_in  (mclk_in),
      .we_in    (id_we),
      .waddr_in ({pbase[3], timer[2:0]}),
      .wdata_in (pbuf[timer[2:0]]),
      .raddr_in (ptr[3:0]),
      .rdata_out(id_rdata)
   );

   // checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   chk_so_release: assert property (state != ST_RD |=> so_oe_b_out)
      else $error("serial output driven outside read data");
   chk_deselect_idle: assert property (cs_rise |=> state == ST_IDLE)
      else $error("not idle after deselect");
   chk_first_bit: assert property (cs_fall |=> state == ST_OPC && bit_cnt == 3'h0)
      else $error("first bit not aligned to select");
   chk_wip_runs: assert property ($rose(wip) |-> wip [*8])
      else $error("write cycle ended early");
   chk_twc_bound: assert property (wip |-> timer < 16'(WRITE_CYCLES))
      else $error("write cycle exceeds its time");
   chk_wel_set: assert property (cs_rise && !wip && state == ST_HOLD && bit_cnt == 3'h0
                                 && opcode == WRITE_LATCH_SET_CMD |=> wel)
      else $error("latch not set");
   chk_wel_clear: assert property ($fell(wip) |-> !wel)
      else $error("latch still set after write");
   chk_out_bit: assert property (state == ST_RD && sck_fall && !load_pend |=> so_out == $past(sout[7]))
      else $error("wrong read bit");
   chk_mfp_hold: assert property (alm0_flag || alm1_flag |=> !mfp_oe_b_out)
      else $error("alarm pin released while flagged");
   chk_unknown_ign: assert property (state == ST_OPC && byte_done && !is_known(in_byte) |=> state == ST_IGN)
      else $error("unknown opcode not ignored");
   chk_clock_wrap: assert property (state == ST_RD && byte_done && opcode == CLOCK_READ_CMD
                                    && ptr == CLOCK_LAST |=> ptr == CLOCK_FIRST)
      else $error("clock space did not wrap");

   cov_launch: cover property (launch);
   cov_status_read: cover property (state == ST_RD && opcode == STATUS_READ_CMD && sck_fall);
   cov_clear: cover property ($fell(clr_run));
   cov_alarm: cover property ($fell(mfp_oe_b_out));
endmodule

//--- hdl/rtccsp_pkg.sv
// constants shared by the serial command port of the clock/calendar device
// assumes a 10 MHz system clock; the link pins are sampled, not used as clocks
package rtccsp_pkg;
   // command opcodes
   localparam logic [7:0] NV_ARRAY_READ_CMD    = 8'h03;
   localparam logic [7:0] NV_ARRAY_WRITE_CMD   = 8'h02;
   localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] WRITE_LATCH_SET_CMD  = 8'h06;
   localparam logic [7:0] STATUS_READ_CMD      = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD     = 8'h01;
   localparam logic [7:0] CLOCK_READ_CMD       = 8'h13;
   localparam logic [7:0] CLOCK_WRITE_CMD      = 8'h12;
   localparam logic [7:0] ID_UNLOCK_CMD        = 8'h14;
   localparam logic [7:0] ID_AREA_WRITE_CMD    = 8'h32;
   localparam logic [7:0] ID_AREA_READ_CMD     = 8'h33;
   localparam logic [7:0] SRAM_CLEAR_CMD       = 8'h54;
   // clock/sram address map
   localparam logic [7:0] CLOCK_FIRST          = 8'h00;
   localparam logic [7:0] CLOCK_LAST           = 8'h1f;
   localparam logic [7:0] SRAM_FIRST           = 8'h20;
   localparam logic [7:0] SRAM_LAST            = 8'h5f;
   localparam logic [7:0] ALARM0_FLAG_ADDR     = 8'h0f;
   localparam logic [7:0] ALARM1_FLAG_ADDR     = 8'h16;
   localparam int         ALARM_FLAG_BIT       = 3;
   // memory shapes
   localparam int         VOL_DEPTH            = 128;
   localparam int         NV_DEPTH             = 256;
   localparam int         ID_DEPTH             = 16;
   localparam int         PAGE_BYTES           = 8;
   localparam int         FIFO_DEPTH           = 32;
   localparam int         FIFO_WIDTH           = 15;
   localparam logic [6:0] SRAM_CLEAR_LAST      = 7'h3f;
   // status byte layout
   localparam int         STATUS_WIP_BIT       = 0;
   localparam int         STATUS_WEL_BIT       = 1;
   localparam int         STATUS_BP_LSB        = 2;
   localparam logic [1:0] BP_RESET             = 2'h0;
   // write cycle time
   localparam int         WRITE_TIME_MS        = 5;
   localparam int         CLK_PERIOD_NS        = 100;
   localparam int         WRITE_CYCLES_DEF     = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   // destination of a buffered nonvolatile page
   typedef enum logic [1:0] {TGT_NV, TGT_ID, TGT_STATUS} rtccsp_tgt_t;
endpackage

//--- hdl/rtccsp_stream_if.sv
// valid/ready word stream between the command port and its write fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface rtccsp_stream_if #(parameter int W = 15);
   logic         valid; // word offered
   logic         ready; // word can be taken
   logic [W-1:0] data;  // word
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- hdl/rtccsp_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module rtccsp_fifo #(
   parameter int W     = 15,
   parameter int DEPTH = 32
) (
   input wire logic     mclk_in,
   input wire logic     rst_b_in,
   rtccsp_stream_if.snk wr_if,
   rtccsp_stream_if.src rd_if
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH]; // storage
   logic [AW:0]  wptr;        // write pointer with wrap bit
   logic [AW:0]  rptr;        // read pointer with wrap bit
   logic         full;        // no free slot
   assign full        = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   assign wr_if.ready = !full;
   assign rd_if.valid = (wptr != rptr);
   assign rd_if.data  = mem[rptr[AW-1:0]];
   // pointers move on accepted words only
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         if (wr_if.valid && !full) begin
            wptr <= wptr + {{AW{1'b0}}, 1'b1};
         end
         if (rd_if.valid && rd_if.ready) begin
            rptr <= rptr + {{AW{1'b0}}, 1'b1};
         end
      end
   end
   // storage write
   always_ff @(posedge mclk_in) begin
      if (wr_if.valid && !full) begin
         mem[wptr[AW-1:0]] <= wr_if.data;
      end
   end
endmodule

//--- hdl/rtccsp_ram.sv
// byte memory with one write port and one registered read port
// assumes one clock; contents are not reset
`timescale 1ns/1ps
module rtccsp_ram #(
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic          mclk_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [7:0]    rdata_out
);
   logic [7:0] mem [DEPTH]; // byte storage
   // write port
   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end
   // registered read
   always_ff @(posedge mclk_in) begin
      rdata_out <= mem[raddr_in];
   end
endmodule

//--- sim/rtccsp_master.sv
// spi master model driving the command port's link pins
// assumes the bench system clock; pins move on its falling edge
`timescale 1ns/1ps
module rtccsp_master (
   input  wire logic mclk_in,
   input  wire logic so_in,
   input  wire logic so_oe_b_in,
   output logic      cs_b_out,
   output logic      sck_out,
   output logic      si_out
);
   // idle: deselected, link clock low
   initial begin
      cs_b_out = 1'b1;
      sck_out  = 1'b0;
      si_out   = 1'b0;
   end
   // wait n falling system clock edges
   task automatic wt(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   // select or release; a released data line flips so stale bits show
   task automatic frame(input logic on);
      wt(4);
      cs_b_out = ~on;
      if (!on) si_out = ~si_out;
      wt(4);
   endtask
   // one byte, msb first, 800 ns link period; so taken at the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] oe);
      for (int i = 7; i >= 0; i--) begin
         si_out  = tx[i];
         wt(4);
         sck_out = 1'b1;
         rx[i]   = so_oe_b_in ? 1'bz : so_in;
         oe[i]   = so_oe_b_in;
         wt(4);
         sck_out = 1'b0;
      end
   endtask
endmodule

//--- sim/rtcc_spi_command_port_tb_top.sv
// self-checking bench for the serial command port
// assumes the master model drives the link, the bench drives the rest
`timescale 1ns/1ps
module rtcc_spi_command_port_tb_top;
   import rtccsp_pkg::*;
   localparam int WCYC = 400;  // shortened write cycle
   logic        mclk = 1'b0;   // system clock
   logic        rst_b = 1'b0;  // reset, low active
   logic [1:0]  alm = 2'h0;    // alarm event pulses
   wire         so, so_oe_b, multifunction_alarm_out, mfp_oe_b, cs_b, sck, si;
   int          error_cnt = 0;
   int          total_checks = 0;
   logic [31:0] seed = 32'h0000000b; // xorshift state
   logic [7:0]  rx, oe, d [3];
   logic [7:0]  base [2] = '{8'h5e, 8'h1f}; // start addresses just below each wrap
   always #50 mclk = ~mclk;
   rtccsp_top #(.WRITE_CYCLES(WCYC)) rtccsp_top_inst (.mclk_in(mclk), .rst_b_in(rst_b), .cs_b_in(cs_b),
      .sck_in(sck), .si_in(si), .alarm0_event_in(alm[0]), .alarm1_event_in(alm[1]), .so_out(so),
      .so_oe_b_out(so_oe_b), .mfp_out(multifunction_alarm_out), .mfp_oe_b_out(mfp_oe_b));
   rtccsp_master rtccsp_master_inst (.mclk_in(mclk), .so_in(so), .so_oe_b_in(so_oe_b), .cs_b_out(cs_b),
      .sck_out(sck), .si_out(si));
   // next random value
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // command, address or write byte: output stays released
   task automatic op(input logic [7:0] b);
      rtccsp_master_inst.xfer(b, rx, oe);
      chk(oe, 8'hff);
   endtask
   // read data byte: output driven throughout
   task automatic rd();
      rtccsp_master_inst.xfer(8'h00, rx, oe);
      chk(oe, 8'h00);
   endtask
   task automatic sel(input logic on);
      rtccsp_master_inst.frame(on);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (30000) @(posedge mclk);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      chk({6'h0, so_oe_b, mfp_oe_b}, 8'h03);
      foreach (d[i]) begin
         seed = xs(seed);
         d[i] = seed[7:0];
      end
      // write across the sram top and the clock top, read back through each wrap
      // no seconds counter runs here, so time writes never meet an increment
      foreach (base[j]) begin
         sel(1); op(CLOCK_WRITE_CMD); op(base[j]);
         foreach (d[i]) op(d[i]);
         sel(0); sel(1); op(CLOCK_READ_CMD); op(base[j]);
         foreach (d[i]) begin
            rd();
            chk(rx, d[i]);
         end
         sel(0);
      end
      $display("test sram done");
      // sram clear, then unknown opcode stays silent
      sel(1); op(SRAM_CLEAR_CMD); sel(0); rtccsp_master_inst.wt(80);
      sel(1); op(CLOCK_READ_CMD); op(8'h5f); rd();
      chk(rx, 8'h00);
      sel(0); sel(1); op(8'hff); op(8'h00); sel(0);
      $display("test clear done");
      // page write wrapping 0x47 to 0x40
      sel(1); op(WRITE_LATCH_SET_CMD); sel(0);
      sel(1); op(NV_ARRAY_WRITE_CMD); op(8'h47); op(d[0]); op(d[1]); sel(0);
      sel(1); op(STATUS_READ_CMD); rd();
      chk(rx & 8'h0f, {4'h0, BP_RESET, 2'h3});
      sel(0); rtccsp_master_inst.wt(WCYC);
      sel(1); op(STATUS_READ_CMD); rd();
      chk(rx & 8'h03, 8'h00);
      sel(0); sel(1); op(NV_ARRAY_READ_CMD); op(8'h40); rd();
      chk(rx, d[1]);
      sel(0); $display("test page done");
      // latch set then cleared: the array write must not start
      sel(1); op(WRITE_LATCH_SET_CMD); sel(0); sel(1); op(WRITE_LATCH_CLEAR_CMD); sel(0);
      sel(1); op(NV_ARRAY_WRITE_CMD); op(8'h40); op(8'h00); sel(0);
      sel(1); op(STATUS_READ_CMD); rd();
      chk(rx & 8'h03, 8'h00);
      sel(0);
      // unlocked id write, read back
      sel(1); op(ID_UNLOCK_CMD); sel(0); sel(1); op(WRITE_LATCH_SET_CMD); sel(0);
      sel(1); op(ID_AREA_WRITE_CMD); op(8'h05); op(d[2]); sel(0); rtccsp_master_inst.wt(WCYC);
      sel(1); op(ID_AREA_READ_CMD); op(8'h05); rd();
      chk(rx, d[2]);
      sel(0);
      // status write lands its protect bits, latch cleared after
      sel(1); op(WRITE_LATCH_SET_CMD); sel(0); sel(1); op(STATUS_WRITE_CMD); op(8'h0c); sel(0);
      rtccsp_master_inst.wt(WCYC);
      sel(1); op(STATUS_READ_CMD); rd();
      chk(rx & 8'h0f, 8'h0c);
      sel(0); $display("test id and status done");
      // each alarm holds the pin low until its flag is cleared
      for (int k = 0; k < 2; k++) begin
         alm[k] = 1'b1;
         @(negedge mclk);
         alm[k] = 1'b0;
         rtccsp_master_inst.wt(3);
         chk({6'h0, multifunction_alarm_out, mfp_oe_b}, 8'h00);
         sel(1); op(CLOCK_WRITE_CMD); op(k ? ALARM1_FLAG_ADDR : ALARM0_FLAG_ADDR); op(8'h00); sel(0);
         chk({7'h0, mfp_oe_b}, 8'h01);
      end
      $display("test alarm done");
      summarize();
   end
endmodule
